// >>> inc/crs_pkg.sv
// Package: encodings, constants and carriers of the CPU register set
// ==========================================================
// Contract
// RULE1 - Accumulator feeds ALU, takes results, loads, stores
// RULE2 - Reset leaves accumulator contents untouched
// RULE3 - Reset clears high index byte, keeps low
// RULE4 - Index pair forms 16-bit pointer, high byte upper
// RULE5 - Indexed modes use full pair; some ops low
// RULE6 - Low index byte clears, counts, inverts, negates, shifts
// RULE7 - Stack pointer marks the next free slot
// RULE8 - Reset loads stack pointer with 0x00FF
// RULE9 - Stack adjust adds signed 8-bit immediate
// RULE10 - Stack reset changes only low pointer byte
// RULE11 - Program counter advances on every fetched byte
// RULE12 - Jumps, branches, interrupts, returns reload counter
// RULE13 - Leaving reset, counter loads vector from top
// RULE14 - Core registers unmapped; one 64-Kbyte space
// RULE15 - Direct addressing reaches only first 256 bytes
// RULE16 - Relative targets use signed 8-bit offset
// RULE17 - Unsigned 8x8 multiply and 16/8 divide
// RULE18 - Taken branch: sign-extend offset, add to counter
// RULE19 - Updates on rising clock; reset values while asserted
package crs_pkg;

  // ==========================================================
  // Reset values and fixed addresses
  localparam logic [7:0] H_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h00ff;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] EA_RST = 16'h0000;
  localparam logic [7:0] SP_RESET_LO = 8'hff;
  localparam logic [15:0] VEC_HI_ADDR = 16'hfffe;
  localparam logic [15:0] VEC_LO_ADDR = 16'hffff;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] SP_STEP = 16'h0001;
  localparam logic [7:0] X_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================
  // Command encodings
  typedef enum logic [2:0] {A_HOLD, A_ALU, A_MEM, A_XFER, A_MUL, A_DIV} crs_a_op_t;
  typedef enum logic [3:0] {
    X_HOLD, X_MEM, X_XFER, X_MUL, X_CLR, X_INC, X_DEC,
    X_COM, X_NEG, X_LSL, X_LSR, X_ASR, X_ROL, X_ROR
  } crs_x_op_t;
  typedef enum logic [1:0] {H_HOLD, H_MEM, H_LOAD16, H_DIV} crs_h_op_t;
  typedef enum logic [2:0] {SP_HOLD, SP_LOAD, SP_ADJ, SP_RESET, SP_PUSH, SP_PULL} crs_sp_op_t;
  typedef enum logic [1:0] {PC_HOLD, PC_FETCH, PC_LOAD, PC_BRANCH} crs_pc_op_t;
  typedef enum logic [2:0] {EA_DIR, EA_EXT, EA_IX, EA_IX_OFF, EA_SP, EA_PC} crs_ea_mode_t;

  // Boot sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_VEC_HI = 3'b001,
    ST_VEC_LO = 3'b010,
    ST_RUN = 3'b100
  } crs_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    crs_a_op_t a_op;
    crs_x_op_t x_op;
    crs_h_op_t h_op;
    crs_sp_op_t sp_op;
    crs_pc_op_t pc_op;
    crs_ea_mode_t ea_mode;
    logic ea_req;
    logic carry_in;
    logic [7:0] imm8;
    logic [15:0] data16;
    logic [7:0] alu_res;
    logic [7:0] mem_data;
  } crs_cmd_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] h;
    logic [7:0] x;
    logic [15:0] sp;
    logic [15:0] pc;
  } crs_regs_t;

  typedef struct packed {
    logic [15:0] mul;
    logic [7:0] quot;
    logic [7:0] rem;
    logic ovf;
  } crs_md_t;

  // Sign extension shared by stack adjust and branch targets
  function automatic logic [15:0] crs_sext8(input logic [7:0] v);
    crs_sext8 = {{8{v[7]}}, v};
  endfunction

endpackage

// >>> rtl/crs_xalu.sv
// Module: low index byte operate unit (clear, count, invert, negate, shift)
`timescale 1ns/1ps
`default_nettype none
module crs_xalu
  import crs_pkg::*;
(
  // Operation and operands
  input wire crs_x_op_t op_i,
  input wire logic [7:0] x_i,
  input wire logic carry_i,
  // Result
  output logic [7:0] res_o,
  output logic carry_o
);

  // ==========================================================
  // Byte operations; carry passes through unless the op defines it
  always_comb begin
    res_o = x_i;
    carry_o = carry_i;
    case (op_i)
      X_CLR: res_o = BYTE_ZERO;
      X_INC: res_o = x_i + X_ONE;
      X_DEC: res_o = x_i - X_ONE;
      X_COM: begin
        res_o = ~x_i;
        carry_o = 1'b1;
      end
      X_NEG: begin
        res_o = BYTE_ZERO - x_i;
        carry_o = (x_i != BYTE_ZERO);
      end
      X_LSL: {carry_o, res_o} = {x_i, 1'b0};
      X_LSR: {res_o, carry_o} = {1'b0, x_i};
      X_ASR: {res_o, carry_o} = {x_i[7], x_i};
      X_ROL: {carry_o, res_o} = {x_i, carry_i};
      X_ROR: {res_o, carry_o} = {carry_i, x_i};
      default: res_o = x_i;
    endcase
  end

endmodule
`default_nettype wire

// >>> rtl/crs_muldiv.sv
// Module: unsigned 8x8 multiply and 16/8 divide
`timescale 1ns/1ps
`default_nettype none
module crs_muldiv
  import crs_pkg::*;
(
  // Operands: A, X and H
  input wire logic [7:0] a_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] h_i,
  // Results
  output crs_md_t res_o
);

  logic [15:0] dividend;
  logic [15:0] divisor;
  logic [15:0] quot_full;
  logic [15:0] rem_full;

  // ==========================================================
  // Divide by zero is steered away from the operator, flagged instead
  always_comb begin
    dividend = {h_i, a_i};
    divisor = {BYTE_ZERO, x_i};
    quot_full = (x_i == BYTE_ZERO) ? 16'h0000 : dividend / divisor; // RULE17
    rem_full = (x_i == BYTE_ZERO) ? 16'h0000 : dividend % divisor;
    res_o.mul = {BYTE_ZERO, a_i} * divisor; // RULE17
    res_o.quot = quot_full[7:0];
    res_o.rem = rem_full[7:0];
    res_o.ovf = (x_i == BYTE_ZERO) || (quot_full[15:8] != BYTE_ZERO);
  end

endmodule
`default_nettype wire

// >>> rtl/crs_top.sv
// Module: programmer-visible register set with reset-vector fetch
`timescale 1ns/1ps
`default_nettype none
module crs_top
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Sequencer command
  input wire crs_cmd_t cmd_i,
  output logic ready_o,
  // Register views and flags
  output crs_regs_t regs_o,
  output logic [7:0] store_data_o,
  output logic x_carry_o,
  output logic div_ovf_o,
  // Memory bus
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i
);

  // ==========================================================
  // State
  crs_state_t state_reg;
  crs_state_t state_next;
  logic [7:0] a_reg;
  logic [7:0] a_next;
  logic [7:0] x_reg;
  logic [7:0] x_next;
  logic [7:0] h_reg;
  logic [7:0] h_next;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [15:0] ea_reg;
  logic [15:0] ea_next;
  logic carry_reg;
  logic carry_next;
  logic ovf_reg;
  logic ovf_next;

  // Combinational helpers
  logic run;
  logic [15:0] hx;
  logic [7:0] xalu_res;
  logic xalu_carry;
  crs_md_t md;

  // Commands are only honoured once the boot vector is in place
  assign run = (state_reg == ST_RUN);
  assign hx = {h_reg, x_reg}; // RULE4

  // ==========================================================
  // Arithmetic units
  crs_xalu crs_xalu_i (
    .op_i(cmd_i.x_op),
    .x_i(x_reg),
    .carry_i(cmd_i.carry_in),
    .res_o(xalu_res),
    .carry_o(xalu_carry)
  );

  crs_muldiv crs_muldiv_i (
    .a_i(a_reg),
    .x_i(x_reg),
    .h_i(h_reg),
    .res_o(md)
  );

  // ==========================================================
  // Accumulator and low index byte
  // Next values for A and X
  always_comb begin
    a_next = a_reg;
    x_next = x_reg;
    if (run) begin
      case (cmd_i.a_op)
        A_ALU: a_next = cmd_i.alu_res; // RULE1
        A_MEM: a_next = cmd_i.mem_data; // RULE1
        A_XFER: a_next = x_reg;
        A_MUL: a_next = md.mul[7:0]; // RULE17
        A_DIV: a_next = md.ovf ? a_reg : md.quot; // RULE17
        default: a_next = a_reg;
      endcase
      case (cmd_i.x_op)
        X_HOLD: x_next = x_reg;
        X_MEM: x_next = cmd_i.mem_data;
        X_XFER: x_next = a_reg;
        X_MUL: x_next = md.mul[15:8]; // RULE17
        default: x_next = xalu_res; // RULE6
      endcase
      // A 16-bit pair load wins over any byte op on X
      if (cmd_i.h_op == H_LOAD16) begin
        x_next = cmd_i.data16[7:0]; // RULE4
      end
    end
  end

  // No reset term on purpose: both bytes survive a reset
  always_ff @(posedge clock_i) begin
    a_reg <= a_next; // RULE2
    x_reg <= x_next; // RULE3
  end

  // ==========================================================
  // High index byte, stack pointer, program counter, boot walk
  // Next values for H, SP, PC and the boot state
  always_comb begin
    h_next = h_reg;
    sp_next = sp_reg;
    pc_next = pc_reg;
    state_next = state_reg;
    case (state_reg)
      ST_VEC_HI: begin
        // Vector is stored high byte first at the lower address
        if (mem_ack_i) begin
          pc_next = {mem_rdata_i, pc_reg[7:0]}; // RULE13
          state_next = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        if (mem_ack_i) begin
          pc_next = {pc_reg[15:8], mem_rdata_i}; // RULE13
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        case (cmd_i.h_op)
          H_MEM: h_next = cmd_i.mem_data;
          H_LOAD16: h_next = cmd_i.data16[15:8]; // RULE4
          H_DIV: h_next = md.ovf ? h_reg : md.rem; // RULE17
          default: h_next = h_reg;
        endcase
        case (cmd_i.sp_op)
          SP_LOAD: sp_next = cmd_i.data16;
          SP_ADJ: sp_next = sp_reg + crs_sext8(cmd_i.imm8); // RULE9
          SP_RESET: sp_next = {sp_reg[15:8], SP_RESET_LO}; // RULE10
          SP_PUSH: sp_next = sp_reg - SP_STEP; // RULE7
          SP_PULL: sp_next = sp_reg + SP_STEP; // RULE7
          default: sp_next = sp_reg;
        endcase
        case (cmd_i.pc_op)
          PC_FETCH: pc_next = pc_reg + PC_STEP; // RULE11
          PC_LOAD: pc_next = cmd_i.data16; // RULE12
          PC_BRANCH: pc_next = pc_reg + crs_sext8(cmd_i.imm8); // RULE16 RULE18
          default: pc_next = pc_reg;
        endcase
      end
      default: state_next = ST_VEC_HI;
    endcase
  end

  // Reset values are forced while reset is low
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      h_reg <= H_RST; // RULE3
      sp_reg <= SP_RST; // RULE8
      pc_reg <= PC_RST;
      state_reg <= ST_VEC_HI; // RULE13
    end else begin
      h_reg <= h_next; // RULE19
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Effective address; registers themselves are never addressable
  // Next address, taken only on request
  always_comb begin
    ea_next = ea_reg;
    if (run && cmd_i.ea_req) begin
      case (cmd_i.ea_mode)
        EA_DIR: ea_next = {DIRECT_PAGE, cmd_i.imm8}; // RULE15
        EA_EXT: ea_next = cmd_i.data16; // RULE14
        EA_IX: ea_next = hx; // RULE5
        EA_IX_OFF: ea_next = hx + cmd_i.data16; // RULE5
        EA_SP: ea_next = sp_reg + cmd_i.data16; // RULE7
        EA_PC: ea_next = pc_reg;
        default: ea_next = ea_reg;
      endcase
    end
  end

  // Registered so the address bus never glitches with the command
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ea_reg <= EA_RST;
    end else begin
      ea_reg <= ea_next;
    end
  end

  // ==========================================================
  // Result flags for the condition-code logic outside
  // Carry follows X ops that define one; overflow follows divides
  always_comb begin
    carry_next = carry_reg;
    ovf_next = ovf_reg;
    // A pair load overrides the X op, so its carry must not leak into the flag
    if (run && cmd_i.h_op != H_LOAD16 &&
        cmd_i.x_op inside {X_COM, X_NEG, X_LSL, X_LSR, X_ASR, X_ROL, X_ROR}) begin
      carry_next = xalu_carry;
    end
    if (run && cmd_i.a_op == A_DIV) begin
      ovf_next = md.ovf;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      carry_reg <= carry_next;
      ovf_reg <= ovf_next;
    end
  end

  // ==========================================================
  // Outputs
  // Vector fetch owns the bus until the counter is loaded
  always_comb begin
    mem_rd_o = 1'b0;
    mem_addr_o = ea_reg;
    case (state_reg)
      ST_VEC_HI: begin
        mem_rd_o = 1'b1;
        mem_addr_o = VEC_HI_ADDR; // RULE13
      end
      ST_VEC_LO: begin
        mem_rd_o = 1'b1;
        mem_addr_o = VEC_LO_ADDR; // RULE13
      end
      default: mem_addr_o = ea_reg;
    endcase
  end

  assign ready_o = run;
  assign store_data_o = a_reg; // RULE1
  assign regs_o = '{a: a_reg, h: h_reg, x: x_reg, sp: sp_reg, pc: pc_reg};
  assign x_carry_o = carry_reg;
  assign div_ovf_o = ovf_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_boot_values: assert property ( // RULE3 RULE8
    !ready_o |-> h_reg == H_RST && sp_reg == SP_RST)
    else $error("H or SP not at reset value during boot");

  chk_acc_boot: assert property ( // RULE2
    // Case equality: A has no reset value, so it is unknown through the first boot
    !ready_o |=> a_reg === $past(a_reg))
    else $error("accumulator changed during boot");

  chk_vec_load: assert property ( // RULE13
    state_reg == ST_VEC_LO && mem_ack_i |=>
      ready_o && pc_reg == {$past(pc_reg[15:8]), $past(mem_rdata_i)})
    else $error("reset vector not loaded into PC");

  chk_pc_fetch: assert property ( // RULE11
    run && cmd_i.pc_op == PC_FETCH ##1 cmd_i.pc_op == PC_FETCH |=>
      pc_reg == $past(pc_reg, 2) + PC_STEP + PC_STEP)
    else $error("PC did not advance per fetch");

  chk_pc_jump: assert property ( // RULE12
    run && cmd_i.pc_op == PC_LOAD |=> pc_reg == $past(cmd_i.data16))
    else $error("change of flow target not loaded");

  chk_pc_branch: assert property ( // RULE18
    run && cmd_i.pc_op == PC_BRANCH |=>
      pc_reg == $past(pc_reg) + crs_sext8($past(cmd_i.imm8)))
    else $error("branch target wrong");

  chk_sp_adjust: assert property ( // RULE9
    run && cmd_i.sp_op == SP_ADJ |=>
      sp_reg == $past(sp_reg) + crs_sext8($past(cmd_i.imm8)))
    else $error("stack adjust result wrong");

  chk_sp_reset_lo: assert property ( // RULE10
    run && cmd_i.sp_op == SP_RESET |=>
      sp_reg[15:8] == $past(sp_reg[15:8]) && sp_reg[7:0] == SP_RESET_LO)
    else $error("stack reset touched high byte");

  chk_acc_load: assert property ( // RULE1
    run && cmd_i.a_op == A_MEM |=> store_data_o == $past(cmd_i.mem_data))
    else $error("accumulator load lost");

  chk_x_inc: assert property ( // RULE6
    run && cmd_i.x_op == X_INC && cmd_i.h_op != H_LOAD16 |=>
      x_reg == $past(x_reg) + X_ONE)
    else $error("X increment wrong");

  chk_ea_direct: assert property ( // RULE15
    run && cmd_i.ea_req && cmd_i.ea_mode == EA_DIR |=>
      mem_addr_o == {DIRECT_PAGE, $past(cmd_i.imm8)})
    else $error("direct address outside first page");

  chk_ea_index: assert property ( // RULE5
    run && cmd_i.ea_req && cmd_i.ea_mode == EA_IX |=>
      mem_addr_o == {$past(h_reg), $past(x_reg)})
    else $error("indexed address not H:X");

  chk_mul_pair: assert property ( // RULE17
    run && cmd_i.a_op == A_MUL && cmd_i.x_op == X_MUL && cmd_i.h_op != H_LOAD16 |=>
      {x_reg, a_reg} == $past(a_reg) * $past(x_reg))
    else $error("multiply result wrong");

  cov_boot_done: cover property (state_reg == ST_VEC_LO && mem_ack_i ##1 ready_o);
  cov_branch: cover property (run && cmd_i.pc_op == PC_BRANCH && cmd_i.imm8[7]);
  cov_div_ovf: cover property (run && cmd_i.a_op == A_DIV && md.ovf);
  cov_sp_reset: cover property (run && cmd_i.sp_op == SP_RESET);

endmodule
`default_nettype wire

// >>> dv/crs_mem_model.sv
// Memory partner that answers the reset-vector reads after a chosen latency
`timescale 1ns/1ps
`default_nettype none
module crs_mem_model
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Read request from the block
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  // Latency and vector contents
  input wire logic [3:0] wait_i,
  input wire logic [15:0] vector_i,
  // Answer
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  // ==========================================================
  // Ack after wait_i idle cycles; data toggles outside the ack so a stale byte never matches
  logic [3:0] cnt_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ack_o <= 1'b0;
      cnt_reg <= 4'h0;
      mem_rdata_o <= 8'h00;
    end else if (mem_ack_o) begin
      mem_ack_o <= 1'b0;
      cnt_reg <= 4'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (mem_rd_i && cnt_reg == wait_i) begin
      mem_ack_o <= 1'b1;
      // High byte of the start address sits at the lower of the two top bytes
      mem_rdata_o <= (mem_addr_i == VEC_HI_ADDR) ? vector_i[15:8] : vector_i[7:0];
    end else begin
      cnt_reg <= mem_rd_i ? cnt_reg + 4'h1 : 4'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the CPU register set
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crs_pkg::*;
  // ==========================================================
  // Signals
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  crs_cmd_t cmd_i = '0;
  crs_cmd_t c;
  crs_regs_t regs_o;
  logic ready_o, x_carry_o, div_ovf_o, mem_rd_o, mem_ack_i;
  logic [7:0] store_data_o, mem_rdata_i;
  logic [15:0] mem_addr_o;
  logic [3:0] wait_i = 4'h0;
  logic [15:0] vector_i = 16'hc123;
  int err_total = 0;
  int total_checks = 0;
  // 50 MHz core clock
  always #10 clock_i = ~clock_i;
  // ==========================================================
  // Block and memory partner
  crs_top crs_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .ready_o(ready_o),
    .regs_o(regs_o), .store_data_o(store_data_o), .x_carry_o(x_carry_o),
    .div_ovf_o(div_ovf_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
  crs_mem_model crs_mem_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .wait_i(wait_i), .vector_i(vector_i),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One command for one edge; called at a falling edge, results settled on return
  task automatic step(input crs_cmd_t k);
    cmd_i = k;
    @(negedge clock_i);
  endtask
  // Reset while a load of A is pending, which must be refused until the vector is in
  task automatic boot(input logic [3:0] lat, input logic [15:0] vec, input logic keep);
    logic [7:0] a0, x0;
    int n;
    a0 = regs_o.a;
    x0 = regs_o.x;
    wait_i = lat;
    vector_i = vec;
    c = '0;
    c.a_op = A_MEM;
    c.mem_data = 8'he7;
    cmd_i = c;
    rst_n_i = 1'b0;
    repeat (5) @(negedge clock_i);
    chk(regs_o.h, H_RST, "h in reset");
    chk(regs_o.sp, SP_RST, "sp in reset");
    chk(ready_o, 1'b0, "ready in reset");
    rst_n_i = 1'b1;
    n = 0;
    while (ready_o !== 1'b1 && n < 60) begin
      @(negedge clock_i);
      n++;
    end
    chk(n < 60, 1'b1, "vector fetch ends");
    chk(regs_o.pc, vec, "pc from vector");
    chk(mem_rd_o, 1'b0, "read released");
    chk(regs_o.h, H_RST, "h after reset");
    chk(regs_o.sp, SP_RST, "sp after reset");
    if (keep) begin
      chk(regs_o.a, a0, "a kept");
      chk(regs_o.x, x0, "x kept");
    end
    step('0);
  endtask
  // ==========================================================
  // Scenarios
  task automatic acc_test();
    c = '0;
    c.a_op = A_MEM;
    c.mem_data = 8'h3c;
    step(c);
    chk(regs_o.a, 8'h3c, "a load");
    chk(store_data_o, 8'h3c, "store data");
    c.a_op = A_ALU;
    c.alu_res = 8'ha5;
    step(c);
    chk(regs_o.a, 8'ha5, "a alu result");
    c.a_op = A_HOLD;
    c.x_op = X_XFER;
    step(c);
    chk(regs_o.x, 8'ha5, "x from a");
    c.x_op = X_MEM;
    c.mem_data = 8'h69;
    step(c);
    c.x_op = X_HOLD;
    c.a_op = A_XFER;
    step(c);
    chk(regs_o.a, 8'h69, "a from x");
  endtask
  task automatic index_test();
    c = '0;
    c.h_op = H_LOAD16;
    c.data16 = 16'h1280;
    step(c);
    chk({regs_o.h, regs_o.x}, 16'h1280, "index pair");
    c.h_op = H_HOLD;
    c.ea_req = 1'b1;
    c.ea_mode = EA_IX;
    step(c);
    chk(mem_addr_o, 16'h1280, "indexed address");
    c.ea_mode = EA_IX_OFF;
    c.data16 = 16'h0010;
    step(c);
    chk(mem_addr_o, 16'h1290, "indexed offset");
    c.ea_mode = EA_DIR;
    c.imm8 = 8'hc8;
    c.data16 = 16'hffff;
    step(c);
    chk(mem_addr_o, 16'h00c8, "direct page");
    c.ea_mode = EA_EXT;
    step(c);
    chk(mem_addr_o, 16'hffff, "extended top");
    c.h_op = H_MEM;
    c.mem_data = 8'h4d;
    c.ea_mode = EA_PC;
    step(c);
    chk(regs_o.h, 8'h4d, "h load");
    chk(mem_addr_o, 16'hc123, "pc as address");
  endtask
  // Load X, apply one operate command, compare result and, where the op defines it, the carry
  task automatic xop(input crs_x_op_t op, input logic [7:0] v, input logic ci,
    input logic [7:0] e, input logic ec);
    c = '0;
    c.x_op = X_MEM;
    c.mem_data = v;
    step(c);
    c.x_op = op;
    c.carry_in = ci;
    step(c);
    chk(regs_o.x, e, "x operate");
    if (op >= X_COM) begin
      chk(x_carry_o, ec, "x carry");
    end
  endtask
  task automatic stack_test();
    c = '0;
    c.sp_op = SP_ADJ;
    c.imm8 = 8'hf0;
    step(c);
    chk(regs_o.sp, 16'h00ef, "adjust down");
    c.imm8 = 8'h7f;
    step(c);
    chk(regs_o.sp, 16'h016e, "adjust up");
    c.sp_op = SP_LOAD;
    c.data16 = 16'h1234;
    step(c);
    c.sp_op = SP_RESET;
    step(c);
    chk(regs_o.sp, 16'h12ff, "stack reset");
    c.sp_op = SP_PUSH;
    step(c);
    c.sp_op = SP_HOLD;
    c.ea_req = 1'b1;
    c.ea_mode = EA_SP;
    c.data16 = 16'h0000;
    step(c);
    chk(mem_addr_o, 16'h12fe, "push slot");
    c.sp_op = SP_PULL;
    step(c);
    chk(regs_o.sp, 16'h12ff, "pull");
  endtask
  task automatic pc_test();
    c = '0;
    c.pc_op = PC_LOAD;
    c.data16 = 16'hfffe;
    step(c);
    chk(regs_o.pc, 16'hfffe, "pc load");
    c.pc_op = PC_FETCH;
    step(c);
    step(c);
    chk(regs_o.pc, 16'h0000, "fetch wraps");
    c.pc_op = PC_BRANCH;
    c.imm8 = 8'hfe;
    step(c);
    chk(regs_o.pc, 16'hfffe, "branch back");
    c.imm8 = 8'h7f;
    step(c);
    chk(regs_o.pc, 16'h007d, "branch forward");
  endtask
  // Multiply, divide, then divide by zero which must leave A and H alone
  task automatic md_test();
    c = '0;
    c.a_op = A_MEM;
    c.mem_data = 8'hc8;
    c.h_op = H_LOAD16;
    c.data16 = 16'h00ff;
    step(c);
    c = '0;
    c.a_op = A_MUL;
    c.x_op = X_MUL;
    step(c);
    chk({regs_o.x, regs_o.a}, 16'hc738, "product");
    c = '0;
    c.a_op = A_MEM;
    c.h_op = H_LOAD16;
    c.data16 = 16'h0105;
    step(c);
    c = '0;
    c.a_op = A_DIV;
    c.h_op = H_DIV;
    step(c);
    chk({regs_o.h, regs_o.a}, 16'h0133, "quotient and remainder");
    chk(div_ovf_o, 1'b0, "no overflow");
    c = '0;
    c.a_op = A_MEM;
    c.h_op = H_LOAD16;
    c.data16 = 16'h0500;
    step(c);
    c = '0;
    c.a_op = A_DIV;
    c.h_op = H_DIV;
    step(c);
    chk({regs_o.h, regs_o.a}, 16'h0500, "overflow keeps");
    chk(div_ovf_o, 1'b1, "overflow flag");
  endtask
  // ==========================================================
  // Main sequence; a slow memory first, a prompt one on the second reset
  initial begin
    @(negedge clock_i);
    boot(4'h5, 16'hc123, 1'b0);
    acc_test();
    index_test();
    xop(X_CLR, 8'h5a, 1'b0, 8'h00, 1'b0);
    xop(X_INC, 8'h7f, 1'b0, 8'h80, 1'b0);
    xop(X_INC, 8'hff, 1'b0, 8'h00, 1'b0);
    xop(X_DEC, 8'h00, 1'b0, 8'hff, 1'b0);
    xop(X_COM, 8'h5a, 1'b0, 8'ha5, 1'b1);
    xop(X_NEG, 8'h01, 1'b0, 8'hff, 1'b1);
    xop(X_LSL, 8'h81, 1'b0, 8'h02, 1'b1);
    xop(X_LSR, 8'h81, 1'b0, 8'h40, 1'b1);
    xop(X_ASR, 8'h81, 1'b0, 8'hc0, 1'b1);
    xop(X_ROL, 8'h80, 1'b1, 8'h01, 1'b1);
    xop(X_ROR, 8'h01, 1'b1, 8'h80, 1'b1);
    xop(X_ROR, 8'h02, 1'b0, 8'h01, 1'b0);
    stack_test();
    pc_test();
    md_test();
    c = '0;
    c.x_op = X_MEM;
    c.mem_data = 8'h9b;
    step(c);
    boot(4'h0, 16'h0200, 1'b1);
    tally_and_finish();
  end
  // Watchdog, far beyond the fewer than a hundred cycles the run needs
  initial begin
    #100000;
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
